/* File: inc/ssp_pkg.sv */
// Purpose: Shared constants and carriers of the serial slave port.
// Assumes: Word length is not fixed by the device; a plain default is used.
// Notes: Pad pull levels live here so that both domains agree on them.

package ssp_pkg;

   // ---------------------------------------------------------------
   // Word format
   // ---------------------------------------------------------------
   localparam int WORD_W = 8;
   localparam int CNT_W = 4;
   localparam logic [CNT_W-1:0] CNT_RST = 4'h0;
   localparam logic [CNT_W-1:0] CNT_LAST = 4'h7;
   localparam logic [WORD_W-1:0] WORD_RST = 8'h00;

   // ---------------------------------------------------------------
   // Pad levels while the far side leaves a pin undriven
   // ---------------------------------------------------------------
   localparam logic PULL_SEL_N = 1'h1;
   localparam logic PULL_SCK = 1'h0;
   localparam logic PULL_SDI = 1'h0;

   // ---------------------------------------------------------------
   // Reset values of single-bit state
   // ---------------------------------------------------------------
   localparam logic BIT_RST = 1'h0;
   localparam logic SYNC_RST = 1'h0;

   // ---------------------------------------------------------------
   // Carriers
   // ---------------------------------------------------------------
   // Pin level together with whether the master drives it
   typedef struct packed {
      logic level;
      logic driven;
   } ssp_pad_s;

   // Received word towards the core logic
   typedef struct packed {
      logic [WORD_W-1:0] data;
      logic valid;
   } ssp_rx_s;

   // Word offered by the core logic for the next transmission
   typedef struct packed {
      logic [WORD_W-1:0] data;
      logic load;
   } ssp_tx_s;

   // Serial output pin: level and output enable
   typedef struct packed {
      logic out;
      logic oe;
   } ssp_pin_out_s;

   // Frame state seen by the core logic
   typedef enum logic [2:0] {
      SSP_IDLE = 3'b001,
      SSP_BUSY = 3'b010,
      SSP_END = 3'b100
   } ssp_frame_e;

endpackage

/* File: rtl/ssp_sync.sv */
// Purpose: Two-flop level synchroniser into the destination clock.
// Assumes: Input level is stable for at least two destination cycles.
// Notes: The first stage feeds only the second stage.

`timescale 1ns/1ps

module ssp_sync #(
   parameter int W = 1
) (
   // Clock and reset of the destination domain
   input wire logic clk,
   input wire logic rst,
   // Asynchronous level in, synchronous level out
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   import ssp_pkg::*;

   logic [W-1:0] meta;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         meta <= '0;
         q <= '0;
      end else begin
         meta <= d;
         q <= meta;
      end
   end

endmodule

/* File: rtl/ssp_top.sv */
// Purpose: Serial peripheral slave port between a master and core logic.
// Assumes: tx word is loaded at least a few sys_clk cycles before a frame.
// Notes: Shift logic runs on the shift clock; received words cross by toggle.

`timescale 1ns/1ps

module ssp_top (
   // System clock and reset
   input wire logic sys_clk,
   input wire logic sys_rst,
   // Pads from the master
   input wire ssp_pkg::ssp_pad_s sel_n_pad,
   input wire ssp_pkg::ssp_pad_s sck_pad,
   input wire ssp_pkg::ssp_pad_s serial_in_pad,
   // Serial output pad
   output ssp_pkg::ssp_pin_out_s serial_out_pin,
   // Core side
   input wire ssp_pkg::ssp_tx_s tx,
   output ssp_pkg::ssp_rx_s rx,
   output logic frame_active,
   output logic frame_done
);
   import ssp_pkg::*;

   // ---------------------------------------------------------------
   // Pad resolution
   // ---------------------------------------------------------------
   wire logic sel_n;
   wire logic link_clk;
   wire logic sdi;

   assign sel_n = sel_n_pad.driven ? sel_n_pad.level
                                   : PULL_SEL_N;
   assign link_clk = sck_pad.driven ? sck_pad.level
                                    : PULL_SCK;
   assign sdi = serial_in_pad.driven ? serial_in_pad.level
                                     : PULL_SDI;

   // Select high holds the link counters, shifters and sdo in reset, so nothing is counted
   // while deselected and each low period starts clean.
   wire logic link_rst;
   assign link_rst = sys_rst | sel_n;

   // ---------------------------------------------------------------
   // Transmit word holding register (sys_clk)
   // ---------------------------------------------------------------
   // Held steady between loads; the link reads it only at word start,
   // which is why loads must not land inside a word.
   logic [WORD_W-1:0] tx_hold;

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         tx_hold <= WORD_RST;
      end else if (tx.load) begin
         tx_hold <= tx.data;
      end
   end

   // ---------------------------------------------------------------
   // Receive shifter on falling shift-clock edges
   // ---------------------------------------------------------------
   logic [CNT_W-1:0] rx_cnt;
   logic [WORD_W-1:0] rx_sr;
   logic [WORD_W-1:0] rx_buf;
   logic rx_tgl;

   wire logic rx_last;
   wire logic [WORD_W-1:0] next_rx_sr;
   wire logic [CNT_W-1:0] next_rx_cnt;

   assign rx_last = (rx_cnt == CNT_LAST);
   // Shift in at the bottom so the first bit ends on top
   assign next_rx_sr = {rx_sr[WORD_W-2:0], sdi};
   assign next_rx_cnt = rx_last ? CNT_RST : rx_cnt + 4'h1;

   always_ff @(negedge link_clk or posedge link_rst) begin
      if (link_rst) begin
         rx_cnt <= CNT_RST;
         rx_sr <= WORD_RST;
      end else begin
         rx_cnt <= next_rx_cnt;
         rx_sr <= next_rx_sr;
      end
   end

   // Completed words survive deselect: buffer and toggle reset by
   // sys_rst only, so a finished word is never dropped at frame end.
   always_ff @(negedge link_clk or posedge sys_rst) begin
      if (sys_rst) begin
         rx_buf <= WORD_RST;
         rx_tgl <= BIT_RST;
      end else if (!sel_n && rx_last) begin
         rx_buf <= next_rx_sr;
         rx_tgl <= ~rx_tgl;
      end
   end

   // ---------------------------------------------------------------
   // Transmit shifter on rising shift-clock edges
   // ---------------------------------------------------------------
   logic [CNT_W-1:0] tx_cnt;
   logic [WORD_W-1:0] tx_sr;
   logic sdo;

   wire logic tx_first;
   wire logic [WORD_W-1:0] tx_word;
   wire logic [CNT_W-1:0] next_tx_cnt;

   assign tx_first = (tx_cnt == CNT_RST);
   // tx_hold is quasi-static here, read only at the word boundary
   assign tx_word = tx_first ? tx_hold : tx_sr;
   assign next_tx_cnt = (tx_cnt == CNT_LAST) ? CNT_RST : tx_cnt + 4'h1;

   always_ff @(posedge link_clk or posedge link_rst) begin
      if (link_rst) begin
         tx_cnt <= CNT_RST;
         tx_sr <= WORD_RST;
         sdo <= BIT_RST;
      end else begin
         tx_cnt <= next_tx_cnt;
         sdo <= tx_word[WORD_W-1];
         tx_sr <= {tx_word[WORD_W-2:0], 1'h0};
      end
   end

   // The master samples on the next falling edge, half a period after
   // the rising-edge update.
   assign serial_out_pin.out = sdo;
   assign serial_out_pin.oe = ~sel_n;

   // ---------------------------------------------------------------
   // Crossings into sys_clk
   // ---------------------------------------------------------------
   wire logic rx_tgl_s;
   wire logic sel_s;

   ssp_sync #(.W(1)) u_sync_tgl (
      .clk(sys_clk),
      .rst(sys_rst),
      .d(rx_tgl),
      .q(rx_tgl_s)
   );

   ssp_sync #(.W(1)) u_sync_sel (
      .clk(sys_clk),
      .rst(sys_rst),
      .d(~sel_n),
      .q(sel_s)
   );

   logic rx_tgl_d;
   logic sel_d;
   wire logic rx_evt;
   wire logic sel_fall;
   wire logic sel_rise;

   assign rx_evt = rx_tgl_s ^ rx_tgl_d;
   assign sel_rise = sel_s & ~sel_d;
   assign sel_fall = ~sel_s & sel_d;

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         rx_tgl_d <= SYNC_RST;
         sel_d <= SYNC_RST;
      end else begin
         rx_tgl_d <= rx_tgl_s;
         sel_d <= sel_s;
      end
   end

   // ---------------------------------------------------------------
   // Received word presentation
   // ---------------------------------------------------------------
   // rx_buf is stable for a whole word time (at least eight link
   // periods) after the toggle, far longer than the sync delay.
   logic [WORD_W-1:0] rx_data;
   logic rx_valid;

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         rx_data <= WORD_RST;
         rx_valid <= BIT_RST;
      end else begin
         rx_valid <= rx_evt;
         if (rx_evt) begin
            rx_data <= rx_buf;
         end
      end
   end

   assign rx.data = rx_data;
   assign rx.valid = rx_valid;

   // ---------------------------------------------------------------
   // Frame tracker
   // ---------------------------------------------------------------
   ssp_frame_e state;
   ssp_frame_e next_state;

   always_comb begin
      next_state = state;
      case (state)
         SSP_IDLE: begin
            if (sel_rise) begin
               next_state = SSP_BUSY;
            end
         end
         SSP_BUSY: begin
            if (sel_fall) begin
               next_state = SSP_END;
            end
         end
         SSP_END: begin
            next_state = sel_s ? SSP_BUSY : SSP_IDLE;
         end
         default: begin
            next_state = SSP_IDLE;
         end
      endcase
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         state <= SSP_IDLE;
      end else begin
         state <= next_state;
      end
   end

   logic active_q;
   logic done_q;

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         active_q <= BIT_RST;
         done_q <= BIT_RST;
      end else begin
         active_q <= (next_state == SSP_BUSY);
         done_q <= (next_state == SSP_END);
      end
   end

   assign frame_active = active_q;
   assign frame_done = done_q;

endmodule

/* File: sim/ssp_top_props.sv */
// Purpose: Port checks of the serial slave port.
// Assumes: tx is loaded only between frames.
// Notes: Mirrors the link shifter to know each expected bit.
`timescale 1ns/1ps
module ssp_top_props (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic sys_rst,
   // Pads
   input wire ssp_pkg::ssp_pad_s sel_n_pad,
   input wire ssp_pkg::ssp_pad_s sck_pad,
   input wire ssp_pkg::ssp_pad_s serial_in_pad,
   input wire ssp_pkg::ssp_pin_out_s serial_out_pin,
   // Core side
   input wire ssp_pkg::ssp_tx_s tx,
   input wire ssp_pkg::ssp_rx_s rx,
   input wire logic frame_active,
   input wire logic frame_done
);
   import ssp_pkg::*;
   // Pad levels as the port resolves them
   wire sel_n = sel_n_pad.driven ? sel_n_pad.level : PULL_SEL_N;
   wire sck = sck_pad.driven ? sck_pad.level : PULL_SCK;
   wire sdi = serial_in_pad.driven ? serial_in_pad.level : PULL_SDI;
   logic [2:0] cnt;
   logic [WORD_W-1:0] sh, wrd, txw;
   logic tg, s1, s2, s3;
   logic [3:0] age;
   // Mirror of the link shifters; sys_rst clears it at start-up too
   always_ff @(negedge sck or posedge sel_n or posedge sys_rst) begin
      if (sel_n || sys_rst) begin
         cnt <= 3'h0;
         sh <= WORD_RST;
      end else begin
         cnt <= cnt + 3'h1;
         sh <= {sh[WORD_W-2:0], sdi};
      end
   end
   always_ff @(negedge sck or posedge sys_rst) begin
      if (sys_rst) begin
         tg <= 1'h0;
         wrd <= WORD_RST;
      end else if (cnt == 3'h7) begin
         tg <= !tg;
         wrd <= {sh[WORD_W-2:0], sdi};
      end
   end
   // Age counts sys cycles since a mirrored word crossed over
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         {s1, s2, s3} <= 3'h0;
         age <= 4'hF;
         txw <= WORD_RST;
      end else begin
         {s1, s2, s3} <= {tg, s1, s2};
         age <= (s2 != s3) ? 4'h0 : age + {3'h0, age != 4'hF};
         if (tx.load) begin
            txw <= tx.data;
         end
      end
   end
   a_oe_select: assert property (
      @(posedge sys_clk) disable iff (sys_rst)
      serial_out_pin.oe == !sel_n) else $error("oe wrong");
   a_out_bit: assert property (
      @(negedge sck) disable iff (sel_n || sys_rst)
      serial_out_pin.out == txw[3'h7 - cnt]) else $error("out bit wrong");
   a_word_in: assert property (
      @(posedge sys_clk) disable iff (sys_rst)
      rx.valid |-> rx.data == wrd) else $error("rx data wrong");
   a_valid_soon: assert property (
      @(posedge sys_clk) disable iff (sys_rst)
      s2 != s3 |-> ##[0:4] rx.valid) else $error("rx valid missing");
   a_valid_pulse: assert property (
      @(posedge sys_clk) disable iff (sys_rst)
      rx.valid |=> !rx.valid) else $error("rx valid too long");
   a_no_stray: assert property (
      @(posedge sys_clk) disable iff (sys_rst)
      rx.valid |-> age < 4'h6) else $error("stray rx valid");
   a_active_rise: assert property (
      @(posedge sys_clk) disable iff (sys_rst)
      $fell(sel_n) |-> ##[1:5] frame_active) else $error("active missing");
   a_done_after: assert property (
      @(posedge sys_clk) disable iff (sys_rst)
      $rose(sel_n) && frame_active |-> ##[1:6] frame_done)
      else $error("no done");
endmodule

/* File: sim/ssp_master_model.sv */
// Purpose: Serial bus master driving the port pads.
// Assumes: Shift clock half period 3 ns, idle low.
// Notes: Released pins show junk; only pulls make them read right.
`timescale 1ns/1ps
module ssp_master_model (
   // Pads towards the port
   output ssp_pkg::ssp_pad_s sel_n_pad,
   output ssp_pkg::ssp_pad_s sck_pad,
   output ssp_pkg::ssp_pad_s serial_in_pad,
   // Port output
   input wire ssp_pkg::ssp_pin_out_s serial_out_pin
);
   import ssp_pkg::*;
   // Pin as the master sees it: floats while the port lets go
   wire sdo_line = serial_out_pin.oe ? serial_out_pin.out : 1'bz;
   task automatic release_pins();
      sel_n_pad = '{1'h0, 1'h0};
      sck_pad = '{1'h1, 1'h0};
      serial_in_pad = '{!serial_in_pad.level, 1'h0};
   endtask
   // Let go only after the bench has raised reset, so no edge is lost
   initial begin
      #2;
      release_pins();
   end
   task automatic frame(input logic [15:0] d, input int n, input bit flt,
                        output logic [15:0] got);
      got = 16'h0000;
      sck_pad = '{1'h0, 1'h1};
      sel_n_pad = '{1'h0, 1'h1};
      for (int i = 0; i < n; i++) begin
         #3;
         sck_pad.level = 1'h1;
         if (flt) begin
            serial_in_pad = '{!serial_in_pad.level, 1'h0};
         end else begin
            serial_in_pad = '{d[15 - i], 1'h1};
         end
         #3;
         got = {got[14:0], sdo_line};
         sck_pad.level = 1'h0;
      end
      #3;
      sel_n_pad = '{1'h1, 1'h1};
      #3;
      release_pins();
   endtask
   // Clocking with select high must be ignored
   task automatic noise(input int n);
      sel_n_pad = '{1'h1, 1'h1};
      repeat (n) begin
         #3;
         sck_pad = '{1'h1, 1'h1};
         serial_in_pad = '{1'($urandom), 1'h1};
         #3;
         sck_pad.level = 1'h0;
      end
      release_pins();
   endtask
endmodule

/* File: sim/spi_slave_serial_port_tb.sv */
// Purpose: Self-checking bench of the serial slave port.
// Assumes: Random words from a fixed seed.
// Notes: Frame lengths 8, 12 and 16 bits cover partial words.
`timescale 1ns/1ps
module spi_slave_serial_port_tb;
   import ssp_pkg::*;
   logic sys_clk, sys_rst, frame_active, frame_done;
   ssp_pad_s sel_n_pad, sck_pad, serial_in_pad;
   ssp_pin_out_s serial_out_pin;
   ssp_tx_s tx;
   ssp_rx_s rx;
   int n_fail = 0;
   int compares = 0;
   int n_done = 0;
   int done_base = 0;
   logic [7:0] rxq[$];
   ssp_top dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .sel_n_pad(sel_n_pad),
      .sck_pad(sck_pad), .serial_in_pad(serial_in_pad),
      .serial_out_pin(serial_out_pin), .tx(tx), .rx(rx),
      .frame_active(frame_active), .frame_done(frame_done));
   ssp_master_model mst (.sel_n_pad(sel_n_pad), .sck_pad(sck_pad),
      .serial_in_pad(serial_in_pad), .serial_out_pin(serial_out_pin));
   initial begin
      sys_clk = 1'h0;
      forever #4 sys_clk = !sys_clk;
   end
   // Outputs are read on the falling edge, clear of their launch
   always @(negedge sys_clk) begin
      if (rx.valid === 1'h1) begin
         rxq.push_back(rx.data);
      end
      if (frame_done === 1'h1) begin
         n_done++;
      end
   end
   task automatic chk_data(input logic [15:0] a, input logic [15:0] e);
      compares++;
      if (a !== e) begin
         n_fail++;
         $display("Error %0t: data %h expected %h", $time, a, e);
      end
   endtask
   task automatic chk_cnt(input int a, input int e);
      compares++;
      if (a != e) begin
         n_fail++;
         $display("Error %0t: count %0d expected %0d", $time, a, e);
      end
   endtask
   function automatic logic [15:0] exp_out(logic [7:0] t, int n);
      return {t, t} >> (16 - n);
   endfunction
   task automatic complete_run();
      if (n_fail == 0 && compares > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   initial begin
      #40000;
      n_fail++;
      complete_run();
   end
   initial begin
      logic [15:0] d, got;
      logic [7:0] t;
      int n;
      sys_rst = 1'h0;
      tx = '{WORD_RST, 1'h0};
      void'($urandom(32'h3b7da028));
      // Raised a step after time zero so every async flop sees the edge
      #1 sys_rst = 1'h1;
      repeat (8) @(posedge sys_clk);
      #1 sys_rst = 1'h0;
      for (int k = 0; k < 12; k++) begin
         rxq.delete();
         done_base = n_done;
         if (k == 6) begin
            #1 mst.noise(10);
         end
         t = 8'($urandom);
         d = 16'($urandom);
         n = 8 + 4 * ((k < 3) ? k : $urandom % 3);
         @(posedge sys_clk);
         #1 tx = '{t, 1'h1};
         @(posedge sys_clk);
         #1 tx.load = 1'h0;
         repeat (3) @(posedge sys_clk);
         #1 mst.frame(d, n, k == 3, got);
         repeat (8) @(posedge sys_clk);
         if (k == 3)
            d = 16'h0000;
         chk_data(got, exp_out(t, n));
         chk_cnt(rxq.size(), n / 8);
         foreach (rxq[i]) begin
            chk_data(rxq[i], d[15 - 8 * i -: 8]);
         end
         chk_cnt(n_done - done_base, 1);
      end
      complete_run();
   end
endmodule
bind ssp_top ssp_top_props chk (.sys_clk(sys_clk), .sys_rst(sys_rst),
   .sel_n_pad(sel_n_pad), .sck_pad(sck_pad), .serial_in_pad(serial_in_pad),
   .serial_out_pin(serial_out_pin), .tx(tx), .rx(rx),
   .frame_active(frame_active), .frame_done(frame_done));
